// *** design/ceb_entry_fmt.sv ***
// formats the four doublewords of one completion entry
`timescale 1ns/1ps
`default_nettype none

module ceb_entry_fmt (
  ceb_entry_if.fmt e          // request in, doublewords out
);

  logic [14:0] status_field;
  logic        success;

  // ---------------------------------------------------------------------------
  // status field and doubleword layout
  // ---------------------------------------------------------------------------
  always_comb begin
    success = (e.cpl.status_code_type == 3'h0) && (e.cpl.sc == 8'h00);
    // a clean completion forces the flags low so the field reads zero
    status_field = success ? 15'h0000 :
      {e.cpl.dnr, e.cpl.more, 2'h0, e.cpl.status_code_type, e.cpl.sc};
    e.dw[0] = e.cpl.dw0_used ? e.cpl.dw0 : 32'h0000_0000;
    e.dw[1] = 32'h0000_0000;
    e.dw[2] = {e.cpl.sq_id, e.cpl.sq_head};
    e.dw[3] = {status_field, e.phase, e.cpl.tag};
  end

endmodule : ceb_entry_fmt

`default_nettype wire

// *** design/ceb_entry_if.sv ***
// carrier between the posting sequencer and the entry formatter
`timescale 1ns/1ps
`default_nettype none

interface ceb_entry_if;
  ceb_pkg::ceb_cpl_t cpl;        // captured request
  logic              phase;      // phase to post with this entry
  logic [31:0]       dw [4];     // formatted doublewords

  modport seq (output cpl, output phase, input dw);
  modport fmt (input cpl, input phase, output dw);
endinterface : ceb_entry_if

`default_nettype wire

// *** design/ceb_params.svh ***
// offsets, field positions, reset values and sizes for the completion builder
`ifndef CEB_PARAMS_SVH
`define CEB_PARAMS_SVH

// ---------------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ---------------------------------------------------------------------------
`define CEB_REG_CTRL      8'h00
`define CEB_REG_CQ_BASE   8'h04
`define CEB_REG_CQ_LAST   8'h08
`define CEB_REG_STATUS    8'h0C
`define CEB_REG_POSTED    8'h10
`define CEB_REG_MD_CFG    8'h14

// ---------------------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------------------
`define CEB_CTRL_EN_BIT     0
`define CEB_STAT_PHASE_BIT  16
`define CEB_STAT_BUSY_BIT   17
`define CEB_MD_SEP_BIT      0
`define CEB_MD_PI_EN_BIT    1
`define CEB_MD_PI_LAST_BIT  2
`define CEB_MD_SIZE_LSB     8
`define CEB_CQ_BASE_RST     32'h0000_0000
`define CEB_CQ_LAST_RST     16'h000F
`define CEB_MD_CFG_RST      32'h0000_0800

// ---------------------------------------------------------------------------
// entry layout
// ---------------------------------------------------------------------------
`define CEB_ENTRY_BYTES   32'h0000_0010
`define CEB_DWORD_BYTES   32'h0000_0004
`define CEB_BEATS_LAST    2'h3
`define CEB_PI_BYTES      8'h08
`define CEB_BLOCK_DWORDS  8'h80
`define CEB_DESC_SEGMENT  4'h2
`define CEB_DESC_LASTSEG  4'h3

`endif

// *** design/ceb_pkg.sv ***
// types shared by the completion entry builder
package ceb_pkg;

  // posting sequencer states
  typedef enum logic [0:0] {
    CEB_IDLE,
    CEB_POST
  } ceb_state_t;

  // one completion request as handed to the formatter
  typedef struct packed {
    logic [15:0] sq_id;
    logic [15:0] sq_head;
    logic [15:0] tag;
    logic [2:0]  status_code_type;
    logic [7:0]  sc;
    logic        more;
    logic        dnr;
    logic [31:0] dw0;
    logic        dw0_used;
  } ceb_cpl_t;

endpackage : ceb_pkg

// *** design/ceb_read_filter.sv ***
// read-path filter: bit-bucket discard, block count, last-segment tracking
`timescale 1ns/1ps
`default_nettype none

`include "ceb_params.svh"

module ceb_read_filter (
  input  wire logic        clk_sys_in,      // system clock
  input  wire logic        rst_in,          // async reset, high
  input  wire logic        clk_en_in,       // freezes state when low
  input  wire logic        start_in,        // new read command
  input  wire logic        beat_valid_in,   // media data dword valid
  input  wire logic [31:0] beat_data_in,    // media data dword
  input  wire logic        bucket_in,       // beat lies under bit bucket
  input  wire logic        desc_valid_in,   // segment descriptor seen
  input  wire logic [3:0]  desc_type_in,    // its descriptor type
  output logic             host_valid_out,  // dword sent to host
  output logic [31:0]      host_data_out,   // dword data
  output logic [15:0]      blocks_out,      // logical blocks accessed
  output logic             final_seg_out,   // now in last segment
  output logic             sgl_err_out      // segment after last segment
);

  logic [7:0]  dw_cnt, next_dw_cnt;
  logic [15:0] next_blocks;
  logic        next_host_valid, next_final, next_err;
  logic [31:0] next_host_data;

  // ---------------------------------------------------------------------------
  // next-value logic
  // ---------------------------------------------------------------------------
  always_comb begin
    next_dw_cnt     = dw_cnt;
    next_blocks     = blocks_out;
    next_final      = final_seg_out;
    next_err        = sgl_err_out;
    next_host_valid = 1'b0;
    next_host_data  = host_data_out;
    if (start_in) begin
      next_dw_cnt = 8'h00;
      next_blocks = 16'h0000;
      next_final  = 1'b0;
      next_err    = 1'b0;
    end else begin
      if (beat_valid_in) begin
        // discarded beats still count toward the blocks accessed
        if (dw_cnt == `CEB_BLOCK_DWORDS - 8'h01) begin
          next_dw_cnt = 8'h00;
          next_blocks = blocks_out + 16'h0001;
        end else begin
          next_dw_cnt = dw_cnt + 8'h01;
        end
        if (!bucket_in) begin
          next_host_valid = 1'b1;
          next_host_data  = beat_data_in;
        end
      end
      if (desc_valid_in) begin
        // a segment pointer inside the final segment is an error
        if (final_seg_out && (desc_type_in == `CEB_DESC_SEGMENT ||
                              desc_type_in == `CEB_DESC_LASTSEG))
          next_err = 1'b1;
        else if (desc_type_in == `CEB_DESC_LASTSEG)
          next_final = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dw_cnt         <= 8'h00;
      blocks_out     <= 16'h0000;
      final_seg_out  <= 1'b0;
      sgl_err_out    <= 1'b0;
      host_valid_out <= 1'b0;
      host_data_out  <= 32'h0000_0000;
    end else if (clk_en_in) begin
      dw_cnt         <= next_dw_cnt;
      blocks_out     <= next_blocks;
      final_seg_out  <= next_final;
      sgl_err_out    <= next_err;
      host_valid_out <= next_host_valid;
      host_data_out  <= next_host_data;
    end
  end

endmodule : ceb_read_filter

`default_nettype wire

// *** design/ceb_top.sv ***
// completion entry builder: posting sequencer, registers, metadata control
`timescale 1ns/1ps
`default_nettype none

`include "ceb_params.svh"

// Overview of operation
// - entries are four doublewords, sixteen bytes
// - dword0 only when used; dword1 reserved
// - phase tag only in final write
// - dword2 high half holds queue id
// - dword2 low half holds sampled head
// - status field in dword3 bits 31:17
// - phase one first pass, then inverts
// - dword3 low half echoes command tag
// - queue id plus tag names command
// - metadata wholly inline or wholly separate
// - metadata committed atomically with block
// - protection info first or last eight
// - bit bucket data never reaches host
// - block count includes discarded blocks
// - last segment descriptor ends list
// - status zero only on clean success
// - type bits 27:25, code 24:17
module ceb_top (
  input  wire logic        clk_sys_in,        // system clock, 20 MHz
  input  wire logic        rst_in,            // async reset, high
  input  wire logic        clk_en_in,         // freezes state when low
  input  wire logic [7:0]  reg_addr_in,       // register byte address
  input  wire logic [31:0] reg_wdata_in,      // register write data
  input  wire logic        reg_wr_in,         // register write strobe
  input  wire logic        reg_rd_in,         // register read strobe
  output logic [31:0]      reg_rdata_out,     // read data, next cycle
  input  wire logic        cpl_valid_in,      // completion request
  output logic             cpl_ready_out,     // request can be taken
  input  wire logic [15:0] cpl_sq_id_in,      // submit_queue_id
  input  wire logic [15:0] cpl_sq_head_in,    // submit_queue_head
  input  wire logic [15:0] cpl_tag_in,        // command_tag
  input  wire logic [2:0]  cpl_sct_in,        // status_code_type
  input  wire logic [7:0]  cpl_sc_in,         // status_code
  input  wire logic        cpl_more_in,       // more status flag
  input  wire logic        cpl_dnr_in,        // do-not-retry flag
  input  wire logic [31:0] cpl_dw0_in,        // command specific dword
  input  wire logic        cpl_dw0_used_in,   // command uses dword 0
  output logic             mem_wr_out,        // host memory write
  output logic [31:0]      mem_addr_out,      // byte address
  output logic [31:0]      mem_data_out,      // dword data
  output logic             mem_last_out,      // final write of entry
  input  wire logic        rd_start_in,       // new read command
  input  wire logic        rd_valid_in,       // media dword valid
  input  wire logic [31:0] rd_data_in,        // media dword
  input  wire logic        rd_bucket_in,      // dword under bit bucket
  input  wire logic        rd_desc_valid_in,  // descriptor seen
  input  wire logic [3:0]  rd_desc_type_in,   // descriptor type
  output logic             host_valid_out,    // dword to host
  output logic [31:0]      host_data_out,     // dword to host data
  output logic [15:0]      rd_blocks_out,     // logical_block_count seen
  output logic             rd_final_seg_out,  // in last segment
  output logic             rd_sgl_err_out,    // bad descriptor in last seg
  input  wire logic        md_blk_done_in,    // block data staged
  input  wire logic        md_meta_done_in,   // its metadata staged
  input  wire logic [1:0]  md_ptr_low_in,     // metadata pointer bits 1:0
  output logic             md_commit_out,     // commit block and metadata
  output logic             md_inline_out,     // metadata in extended block
  output logic             md_separate_out,   // metadata in metadata_region
  output logic [7:0]       md_pi_offset_out,  // protection info byte offset
  output logic             md_ptr_err_out     // pointer not dword aligned
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  ceb_pkg::ceb_state_t state, next_state;
  ceb_pkg::ceb_cpl_t   cpl_q, next_cpl;
  logic        controller_enable, next_enable;
  logic [31:0] cq_base, next_base;
  logic [15:0] cq_last, next_last;
  logic [15:0] tail, next_tail;
  logic        phase, next_phase;
  logic [1:0]  beat, next_beat;
  logic [31:0] posted, next_posted;
  logic [31:0] md_cfg, next_md_cfg;
  logic [31:0] next_rdata;
  logic        next_ready, next_mem_wr, next_mem_last;
  logic [31:0] next_mem_addr, next_mem_data;
  logic        blk_staged, next_blk_staged;
  logic        meta_staged, next_meta_staged;
  logic        next_commit, next_inline, next_separate, next_ptr_err;
  logic [7:0]  next_pi_offset;
  logic        take;
  logic [7:0]  md_size;

  ceb_entry_if ent ();

  // ---------------------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------------------
  ceb_entry_fmt u_fmt (
    .e (ent.fmt)
  );

  ceb_read_filter u_filt (
    .clk_sys_in     (clk_sys_in),
    .rst_in         (rst_in),
    .clk_en_in      (clk_en_in),
    .start_in       (rd_start_in),
    .beat_valid_in  (rd_valid_in),
    .beat_data_in   (rd_data_in),
    .bucket_in      (rd_bucket_in),
    .desc_valid_in  (rd_desc_valid_in),
    .desc_type_in   (rd_desc_type_in),
    .host_valid_out (host_valid_out),
    .host_data_out  (host_data_out),
    .blocks_out     (rd_blocks_out),
    .final_seg_out  (rd_final_seg_out),
    .sgl_err_out    (rd_sgl_err_out)
  );

  assign ent.cpl   = cpl_q;
  assign ent.phase = phase;
  assign take      = cpl_valid_in && cpl_ready_out;
  assign md_size   = md_cfg[`CEB_MD_SIZE_LSB +: 8];

  // ---------------------------------------------------------------------------
  // register writes; enable edge restarts the queue at slot zero
  // ---------------------------------------------------------------------------
  always_comb begin
    next_enable = controller_enable;
    next_base   = cq_base;
    next_last   = cq_last;
    next_md_cfg = md_cfg;
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `CEB_REG_CTRL:    next_enable = reg_wdata_in[`CEB_CTRL_EN_BIT];
        `CEB_REG_CQ_BASE: next_base   = reg_wdata_in;
        `CEB_REG_CQ_LAST: next_last   = reg_wdata_in[15:0];
        `CEB_REG_MD_CFG:  next_md_cfg = reg_wdata_in;
        default:          next_enable = controller_enable;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // register reads; unmapped addresses answer zero
  // ---------------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `CEB_REG_CTRL:    next_rdata[`CEB_CTRL_EN_BIT] = controller_enable;
        `CEB_REG_CQ_BASE: next_rdata = cq_base;
        `CEB_REG_CQ_LAST: next_rdata = {16'h0000, cq_last};
        `CEB_REG_STATUS:  next_rdata = {14'h0000, state == ceb_pkg::CEB_POST,
                                        phase, tail};
        `CEB_REG_POSTED:  next_rdata = posted;
        `CEB_REG_MD_CFG:  next_rdata = md_cfg;
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // posting sequencer: one request becomes four dword writes
  // ---------------------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_cpl      = cpl_q;
    next_tail     = tail;
    next_phase    = phase;
    next_beat     = beat;
    next_posted   = posted;
    next_mem_wr   = 1'b0;
    next_mem_last = 1'b0;
    next_mem_addr = mem_addr_out;
    next_mem_data = mem_data_out;
    unique case (state)
      ceb_pkg::CEB_IDLE: begin
        if (take) begin
          // head is frozen here, when the entry is created
          next_cpl.sq_id    = cpl_sq_id_in;
          next_cpl.sq_head  = cpl_sq_head_in;
          next_cpl.tag      = cpl_tag_in;
          next_cpl.status_code_type      = cpl_sct_in;
          next_cpl.sc       = cpl_sc_in;
          next_cpl.more     = cpl_more_in;
          next_cpl.dnr      = cpl_dnr_in;
          next_cpl.dw0      = cpl_dw0_in;
          next_cpl.dw0_used = cpl_dw0_used_in;
          next_beat         = 2'h0;
          next_state        = ceb_pkg::CEB_POST;
        end
      end
      ceb_pkg::CEB_POST: begin
        next_mem_wr   = 1'b1;
        next_mem_addr = cq_base + {tail, 4'h0}
                      + ({30'h0, beat} * `CEB_DWORD_BYTES);
        next_mem_data = ent.dw[beat];
        // phase lives in dword 3, written last
        next_mem_last = (beat == `CEB_BEATS_LAST);
        next_beat     = beat + 2'h1;
        if (beat == `CEB_BEATS_LAST) begin
          next_state  = ceb_pkg::CEB_IDLE;
          next_posted = posted + 32'h0000_0001;
          if (tail == cq_last) begin
            next_tail  = 16'h0000;
            next_phase = ~phase;
          end else begin
            next_tail  = tail + 16'h0001;
          end
        end
      end
    endcase
    // disabled queue rests at slot zero with phase one for the first pass
    if (!next_enable) begin
      next_tail  = 16'h0000;
      next_phase = 1'b1;
    end
    next_ready = next_enable && (next_state == ceb_pkg::CEB_IDLE);
  end

  // ---------------------------------------------------------------------------
  // metadata placement: exclusive routing, joint commit, pi location
  // ---------------------------------------------------------------------------
  always_comb begin
    next_blk_staged  = blk_staged || md_blk_done_in;
    next_meta_staged = meta_staged || md_meta_done_in;
    next_commit      = 1'b0;
    // nothing is committed until block and metadata are both staged
    if (next_blk_staged && next_meta_staged) begin
      next_commit      = 1'b1;
      next_blk_staged  = blk_staged && md_blk_done_in;
      next_meta_staged = meta_staged && md_meta_done_in;
    end
    next_separate  = md_cfg[`CEB_MD_SEP_BIT];
    next_inline    = ~md_cfg[`CEB_MD_SEP_BIT];
    // a misaligned pointer is flagged rather than silently rounded
    next_ptr_err   = md_cfg[`CEB_MD_SEP_BIT] &&
                     (md_ptr_low_in != 2'h0);
    next_pi_offset = 8'h00;
    if (md_cfg[`CEB_MD_PI_EN_BIT] && md_cfg[`CEB_MD_PI_LAST_BIT])
      next_pi_offset = md_size - `CEB_PI_BYTES;
  end

  // ---------------------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state             <= ceb_pkg::CEB_IDLE;
      cpl_q             <= '0;
      controller_enable <= 1'b0;
      cq_base           <= `CEB_CQ_BASE_RST;
      cq_last           <= `CEB_CQ_LAST_RST;
      md_cfg            <= `CEB_MD_CFG_RST;
      tail              <= 16'h0000;
      phase             <= 1'b1;
      beat              <= 2'h0;
      posted            <= 32'h0000_0000;
      reg_rdata_out     <= 32'h0000_0000;
      cpl_ready_out     <= 1'b0;
      mem_wr_out        <= 1'b0;
      mem_addr_out      <= 32'h0000_0000;
      mem_data_out      <= 32'h0000_0000;
      mem_last_out      <= 1'b0;
      blk_staged        <= 1'b0;
      meta_staged       <= 1'b0;
      md_commit_out     <= 1'b0;
      md_inline_out     <= 1'b0;
      md_separate_out   <= 1'b0;
      md_pi_offset_out  <= 8'h00;
      md_ptr_err_out    <= 1'b0;
    end else if (clk_en_in) begin
      state             <= next_state;
      cpl_q             <= next_cpl;
      controller_enable <= next_enable;
      cq_base           <= next_base;
      cq_last           <= next_last;
      md_cfg            <= next_md_cfg;
      tail              <= next_tail;
      phase             <= next_phase;
      beat              <= next_beat;
      posted            <= next_posted;
      reg_rdata_out     <= next_rdata;
      cpl_ready_out     <= next_ready;
      mem_wr_out        <= next_mem_wr;
      mem_addr_out      <= next_mem_addr;
      mem_data_out      <= next_mem_data;
      mem_last_out      <= next_mem_last;
      blk_staged        <= next_blk_staged;
      meta_staged       <= next_meta_staged;
      md_commit_out     <= next_commit;
      md_inline_out     <= next_inline;
      md_separate_out   <= next_separate;
      md_pi_offset_out  <= next_pi_offset;
      md_ptr_err_out    <= next_ptr_err;
    end
  end

endmodule : ceb_top

`default_nettype wire

// *** tb/ceb_checker.sv ***
// concurrent checks on the completion entry builder ports
`timescale 1ns/1ps
`default_nettype none
module ceb_checker (
  input wire logic        clk_sys_in,      // clock
  input wire logic        rst_in,          // reset
  input wire logic        cpl_valid_in,    // request
  input wire logic        cpl_ready_out,   // ready
  input wire logic [15:0] cpl_sq_id_in,    // queue id
  input wire logic [15:0] cpl_sq_head_in,  // queue head
  input wire logic [15:0] cpl_tag_in,      // tag
  input wire logic [2:0]  cpl_sct_in,      // code type
  input wire logic [7:0]  cpl_sc_in,       // code
  input wire logic        mem_wr_out,      // write
  input wire logic [31:0] mem_data_out,    // data
  input wire logic        mem_last_out,    // last write
  input wire logic        md_blk_done_in,  // block staged
  input wire logic        md_meta_done_in, // metadata staged
  input wire logic        md_commit_out    // commit
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // fields are sampled on the take edge, so checks count from it
  wire take = cpl_valid_in && cpl_ready_out;
  sequence burst_s; mem_wr_out [*4] ##1 !mem_wr_out; endsequence
  sequence last_s; !mem_last_out [*3] ##1 mem_last_out; endsequence
  entry_len_a: assert property ($rose(mem_wr_out) |-> burst_s)
    else $error("entry is not four writes");
  phase_last_a: assert property ($rose(mem_wr_out) |-> last_s)
    else $error("last write misplaced");
  dw1_zero_a: assert property ($rose(mem_wr_out) |=> !mem_data_out)
    else $error("dword one not zero");
  take_lat_a: assert property (take |-> ##1 !mem_wr_out ##1 mem_wr_out)
    else $error("write late after take");
  dw2_ids_a: assert property (take |-> ##4 mem_data_out ==
    {$past(cpl_sq_id_in, 4), $past(cpl_sq_head_in, 4)})
    else $error("dword two wrong");
  tag_echo_a: assert property (take |-> ##5 mem_last_out &&
    mem_data_out[15:0] == $past(cpl_tag_in, 5)) else $error("tag wrong");
  code_pos_a: assert property (take |-> ##5 mem_data_out[27:17] ==
    {$past(cpl_sct_in, 5), $past(cpl_sc_in, 5)}) else $error("code wrong");
  ok_zero_a: assert property (take && cpl_sct_in == 3'h0 &&
    cpl_sc_in == 8'h00 |-> ##5 mem_data_out[31:17] == 15'h0)
    else $error("success status not zero");
  commit_a: assert property (md_blk_done_in && md_meta_done_in
    |=> md_commit_out) else $error("no commit");
endmodule : ceb_checker
bind ceb_top ceb_checker u_chk (.*);
`default_nettype wire

// *** tb/ceb_host_mem.sv ***
// host memory model: stores entry writes, hands back whole entries
`timescale 1ns/1ps
`default_nettype none
module ceb_host_mem (
  input  wire logic        clk_in,    // clock
  input  wire logic        wr_in,     // write
  input  wire logic [31:0] addr_in,   // byte address
  input  wire logic [31:0] data_in,   // dword
  input  wire logic        last_in,   // final write of entry
  output logic             done_out,  // whole entry seen
  output logic [159:0]     entry_out  // last address, dwords 3..0
);
  logic [31:0]     mem [256];
  wire logic [7:0] a = addr_in[9:2];
  // slots start with phase clear, as software must leave them
  initial foreach (mem[i]) mem[i] = 32'h0;
  // earlier dwords are read back from memory, so a wrong address shows
  always @(posedge clk_in) begin
    done_out <= wr_in && last_in;
    if (wr_in) mem[a] <= data_in;
    if (wr_in && last_in) entry_out <= {addr_in, data_in,
      mem[a - 8'h1], mem[a - 8'h2], mem[a - 8'h3]};
  end
endmodule : ceb_host_mem
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the completion entry builder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0, cpl_valid_in = 1'b0, cpl_more_in = 1'b0;
  logic        cpl_dnr_in = 1'b0, cpl_dw0_used_in = 1'b0, rd_start_in = 1'b0;
  logic        rd_valid_in = 1'b0, rd_bucket_in = 1'b0, md_blk_done_in = 1'b0;
  logic        rd_desc_valid_in = 1'b0, md_meta_done_in = 1'b0, ph = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00, cpl_sc_in = 8'h00, md_pi_offset_out;
  logic [31:0] reg_wdata_in = 32'h0, cpl_dw0_in = 32'h0, rd_data_in = 32'h0;
  logic [15:0] cpl_sq_id_in = 16'h0, cpl_sq_head_in = 16'h0, tail = 16'h0;
  logic [15:0] cpl_tag_in = 16'h0, rd_blocks_out;
  logic [2:0]  cpl_sct_in = 3'h0;
  logic [3:0]  rd_desc_type_in = 4'h0;
  logic [1:0]  md_ptr_low_in = 2'h0;
  logic [31:0] reg_rdata_out, mem_addr_out, mem_data_out, host_data_out, r;
  logic        cpl_ready_out, mem_wr_out, mem_last_out, host_valid_out, done;
  logic        rd_final_seg_out, rd_sgl_err_out, md_commit_out, rd_d = 1'b0;
  logic        md_inline_out, md_separate_out, md_ptr_err_out;
  logic [159:0] entry, q_reg[$], q_ent[$], q_host[$];
  logic [31:0] seed = 32'h0001_3FA2;
  int          miscompares = 0, samples_checked = 0, i, k;

  ceb_top u_dut (.*, .clk_en_in(1'b1));
  ceb_host_mem u_host (.clk_in(clk_sys_in), .wr_in(mem_wr_out),
    .addr_in(mem_addr_out), .data_in(mem_data_out), .last_in(mem_last_out),
    .done_out(done), .entry_out(entry));

  // 20 MHz clock
  always #25 clk_sys_in = !clk_sys_in;

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic check(input string n, input logic [159:0] e, g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // one access, then a free cycle so strobes never rise twice in a step
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    if (!w) q_reg.push_back({128'h0, d});
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} <= {a, d, w, !w};
    @(posedge clk_sys_in);
    {reg_wr_in, reg_rd_in} <= 2'b00;
    @(posedge clk_sys_in);
  endtask : bus

  // one completion request; the expected entry is noted before the take
  task automatic post(input logic [2:0] t);
    logic [7:0]  sc;
    logic [14:0] st;
    r = rnd();
    sc = (t == 3'h0) ? 8'h00 : r[7:0];
    st = (sc == 8'h00 && t == 3'h0) ? 15'h0 : {r[10:9], 2'b00, t, sc};
    q_ent.push_back({32'h0000_1000 + {12'h0, tail, 4'hC}, st, ph, r[23:8],
      r, 32'h0, r[11] ? r : 32'h0});
    {tail, ph} = (tail == 16'h2) ? {16'h0, !ph} : {tail + 16'h1, ph};
    {cpl_sq_id_in, cpl_sq_head_in, cpl_tag_in} <= {r, r[23:8]};
    {cpl_sct_in, cpl_sc_in, cpl_dnr_in, cpl_more_in} <= {t, sc, r[10:9]};
    {cpl_dw0_in, cpl_dw0_used_in, cpl_valid_in} <= {r, r[11], 1'b1};
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (!cpl_ready_out && k < 20);
    if (!cpl_ready_out) miscompares++;
    if (!cpl_ready_out) end_sim();
    cpl_valid_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask : post

  // results are settled mid-cycle and matched against the oldest note
  always @(posedge clk_sys_in) rd_d <= reg_rd_in;
  always @(negedge clk_sys_in) begin
    if (rd_d) check("rdata", q_reg.pop_front(), reg_rdata_out);
    if (done) check("entry", q_ent.pop_front(), entry);
    if (host_valid_out) check("host", q_host.pop_front(), host_data_out);
  end

  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    bus(1'b0, 8'h08, 32'h0000_000F);
    bus(1'b0, 8'h14, 32'h0000_0800);
    bus(1'b1, 8'h20, 32'h0000_0005);
    bus(1'b0, 8'h20, 32'h0);
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
    bus(1'b1, 8'h04, 32'h0000_1000);
    bus(1'b1, 8'h08, 32'h0000_0002);
    bus(1'b1, 8'h00, 32'h0000_0001);
    bus(1'b0, 8'h0C, 32'h0001_0000);
    for (i = 0; i < 8; i++) post(i[2:0]);
    // two blocks, the first half of the second under a bit bucket
    rd_start_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_start_in <= 1'b0;
    for (i = 0; i < 256; i++) begin
      r = rnd();
      {rd_valid_in, rd_data_in, rd_bucket_in} <= {1'b1, r, i[7:6] == 2'h2};
      if (i[7:6] != 2'h2) q_host.push_back({128'h0, r});
      @(posedge clk_sys_in);
    end
    rd_valid_in <= 1'b0;
    for (i = 2; i < 5; i++) begin
      {rd_desc_valid_in, rd_desc_type_in} <= {1'b1, 3'h1, i[0]};
      @(posedge clk_sys_in);
      rd_desc_valid_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      check("rd", {16'h2, i > 2, i > 3},
        {rd_blocks_out, rd_final_seg_out, rd_sgl_err_out});
    end
    bus(1'b0, 8'h10, 32'h0000_0008);
    bus(1'b0, 8'h0C, {15'h0, ph, tail});
    md_ptr_low_in <= 2'h2;
    bus(1'b1, 8'h14, 32'h0000_1007);
    @(posedge clk_sys_in);
    check("md", {2'b01, 8'h08, 1'b1}, {md_inline_out, md_separate_out,
      md_pi_offset_out, md_ptr_err_out});
    {md_blk_done_in, md_meta_done_in} <= 2'b11;
    @(posedge clk_sys_in);
    {md_blk_done_in, md_meta_done_in} <= 2'b00;
    @(posedge clk_sys_in);
    check("commit", 1'b1, md_commit_out);
    for (i = 0; i < 40 && q_ent.size() + q_host.size() > 0; i++)
      @(posedge clk_sys_in);
    if (i == 40) miscompares++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
